// ===== verilog/lpmc_cfg.svh
/*
 low power mode controller: register offsets, field positions, reset values.
 assumes inclusion by the controller and the testbench only.
*/
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH
`define LPMC_ADDR_W 8
`define LPMC_OFF_CTRL 8'h00
`define LPMC_OFF_OSC 8'h04
`define LPMC_OFF_STAT 8'h08
`define LPMC_OFF_IRQ_STAT 8'h0C
`define LPMC_OFF_IRQ_EN 8'h10
`define LPMC_OFF_IRQ_CLR 8'h14
`define LPMC_CTRL_MODE_LSB 0
`define LPMC_CTRL_MODE_MSB 2
`define LPMC_CTRL_LPREG 3
`define LPMC_CTRL_RANGE_LSB 4
`define LPMC_CTRL_RANGE_MSB 5
`define LPMC_CTRL_DEEPSEL 6
`define LPMC_CTRL_ISRRET 7
`define LPMC_CTRL_PEND_EV 8
`define LPMC_CTRL_RESET 32'h0000_0010
`define LPMC_OSC_CAL 0
`define LPMC_OSC_LSI 1
`define LPMC_OSC_LSE 2
`define LPMC_OSC_XHS 3
`define LPMC_OSC_PLL 4
`define LPMC_OSC_RESET 32'h0000_0000
`define LPMC_MODE_STOP0 3'h0
`define LPMC_RANGE1 2'h1
`define LPMC_IRQ_W 3
`define LPMC_RESP_OKAY 2'h0
`define LPMC_RESP_SLVERR 2'h2
`endif

// ===== verilog/lpmc_pkg.sv
/*
 low power mode controller types.
 assumes lpmc_cfg.svh on the include path.
*/
package lpmc_pkg;
    typedef enum logic [2:0] {
        LPMC_RUN = 3'h0,
        LPMC_LPRUN = 3'h1,
        LPMC_SLEEP = 3'h2,
        LPMC_LPSLEEP = 3'h3,
        LPMC_STOP_WAIT = 3'h4,
        LPMC_STOP0 = 3'h5
    } lpmc_state_e;

    typedef enum logic [1:0] {
        LPMC_BY_WAIT_IRQ = 2'h0,
        LPMC_BY_WAIT_EVT = 2'h1,
        LPMC_BY_EXIT = 2'h2
    } lpmc_entry_e;

    typedef struct packed {
        logic wait_interrupt_instr;
        logic wait_event_instr;
        logic isr_return;
        logic irq_pending;
        logic irq_pending_any;
        logic event_pending;
        logic wakeup_event;
    } lpmc_core_s;

    typedef struct packed {
        logic core_clk_en;
        logic pll_en;
        logic internal_16mhz_osc_en;
        logic external_highspeed_osc_en;
        logic main_regulator_on;
        logic io_hold;
        logic sram_retain;
        logic sysclk_internal;
    } lpmc_clk_s;
endpackage

// ===== verilog/lpmc_ctrl.sv
/*
 low power mode controller: run, low-power run, sleep, low-power sleep and stop 0,
 with an axi4-lite register slave and an interrupt output.
 assumes synchronous inputs on clk, and core request pulses lasting one cycle.
*/
// What this block does
// - wake from low-power sleep returns to low-power run mode
// - low-power sleep entered only from low-power run, no pending work
// - isr return with sleep_on_isr_return set enters sleep
// - interrupt wait or isr return wakes on interrupt; event wait on event only
// - event wait with pending_as_event wakes on any interrupt or event
// - stop 0 keeps main regulator, stops core clocks and fast oscillators
// - serial peripheral may get internal 16 MHz clock alone in stop 0
// - stop 0 retains sram, registers and io pin states
// - deep_sleep_select set turns a low-power request into stop 0
// - flash programming postpones stop 0 entry
// - ongoing peripheral bus access postpones stop 0 entry
// - independent watchdog once started runs until reset
// - calendar clock and slow external oscillator follow their own enables; slow internal oscillator also runs while the watchdog runs
// - stop 0 wakeup selects the internal system clock source
// - stop 0 exit gives low-power run or run as low_power_regulator_request selects
// - deep sleep selects stop 0 only when mode select is 000
// - pending external events or wakeup flags cancel stop 0 request
`include "lpmc_cfg.svh"
module lpmc_ctrl import lpmc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // axi4-lite slave
    input wire logic [`LPMC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`LPMC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core requests and wakeup sources
    input wire lpmc_core_s core,
    input wire logic ext_pending_any,
    input wire logic periph_wakeup_flag,
    // stop 0 entry holds
    input wire logic flash_prog_busy,
    input wire logic apb_busy,
    // watchdog start
    input wire logic wdg_key_start,
    input wire logic wdg_hw_option,
    // serial wakeup clock request
    input wire logic serial_clk_req,
    // clock and power controls
    output lpmc_clk_s clk_ctrl,
    output logic serial_clk_en,
    output logic watchdog_run,
    output logic calendar_clk_en,
    output logic slow_internal_osc_en,
    output logic slow_external_osc_en,
    output logic cpu_sleeping,
    output logic [2:0] power_mode,
    output logic irq
);
    lpmc_state_e state;
    lpmc_state_e next_state;
    lpmc_entry_e entry;
    logic [31:0] ctrl;
    logic [31:0] osc;
    logic [`LPMC_IRQ_W-1:0] irq_stat;
    logic [`LPMC_IRQ_W-1:0] irq_en;
    logic wdg_on;
    logic aw_held;
    logic w_held;
    logic [`LPMC_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    function automatic logic [31:0] lpmc_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // control fields
    wire logic low_power_regulator_request = ctrl[`LPMC_CTRL_LPREG];
    wire logic deep_sleep_select = ctrl[`LPMC_CTRL_DEEPSEL];
    wire logic sleep_on_isr_return = ctrl[`LPMC_CTRL_ISRRET];
    wire logic pending_as_event = ctrl[`LPMC_CTRL_PEND_EV];
    wire logic [2:0] low_power_mode_select = ctrl[`LPMC_CTRL_MODE_MSB:`LPMC_CTRL_MODE_LSB];
    wire logic low_run = (state == LPMC_LPRUN);
    wire logic in_run = (state == LPMC_RUN) || low_run;

    // request decode
    // no pending interrupt or event
    wire logic req_wait_irq = core.wait_interrupt_instr && !core.irq_pending;
    wire logic req_wait_evt = core.wait_event_instr && !core.event_pending;
    wire logic req_exit = core.isr_return && sleep_on_isr_return && !core.irq_pending;
    wire logic lp_req = in_run && (req_wait_irq || req_wait_evt || req_exit);
    wire logic stop_req = lp_req && deep_sleep_select && (low_power_mode_select == `LPMC_MODE_STOP0);
    wire logic sleep_req = lp_req && !deep_sleep_select;
    wire logic stop_cancel = ext_pending_any || periph_wakeup_flag;
    wire logic stop_hold = flash_prog_busy || apb_busy;
    lpmc_entry_e next_entry;
    assign next_entry = req_wait_evt ? LPMC_BY_WAIT_EVT : (req_wait_irq ? LPMC_BY_WAIT_IRQ : LPMC_BY_EXIT);

    // wakeup decode
    // interrupt or event by entry
    // any interrupt when pending as event
    wire logic wake = (entry == LPMC_BY_WAIT_EVT) ?
        (core.wakeup_event || (pending_as_event && core.irq_pending_any)) : core.irq_pending;
    wire logic run_after = low_power_regulator_request;

    always_comb begin
        next_state = state;
        case (state)
            LPMC_RUN, LPMC_LPRUN: begin
                if (stop_req && !stop_cancel) begin
                    next_state = stop_hold ? LPMC_STOP_WAIT : LPMC_STOP0;
                end else if (sleep_req) begin
                    next_state = low_run ? LPMC_LPSLEEP : LPMC_SLEEP;
                end else begin
                    next_state = low_power_regulator_request ? LPMC_LPRUN : LPMC_RUN;
                end
            end
            LPMC_SLEEP: begin
                if (wake) begin
                    next_state = LPMC_RUN;
                end
            end
            LPMC_LPSLEEP: begin
                if (wake) begin
                    next_state = LPMC_LPRUN;
                end
            end
            LPMC_STOP_WAIT: begin
                if (stop_cancel) begin
                    next_state = run_after ? LPMC_LPRUN : LPMC_RUN;
                end else if (!stop_hold) begin
                    next_state = LPMC_STOP0;
                end
            end
            LPMC_STOP0: begin
                if (wake || stop_cancel) begin
                    next_state = run_after ? LPMC_LPRUN : LPMC_RUN;
                end
            end
            default: next_state = LPMC_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= LPMC_RUN;
            entry <= LPMC_BY_WAIT_IRQ;
        end else begin
            state <= next_state;
            if (lp_req) begin
                entry <= next_entry;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wdg_on <= 1'b0;
        end else if (wdg_key_start || wdg_hw_option) begin
            wdg_on <= 1'b1;
        end
    end

    // clock and power outputs
    wire logic in_stop = (state == LPMC_STOP0);
    wire logic stop_exit = in_stop && (next_state != LPMC_STOP0);
    always_ff @(posedge clk) begin
        if (!nrst) begin
            clk_ctrl <= '{default: 1'b0, main_regulator_on: 1'b1, core_clk_en: 1'b1,
                          internal_16mhz_osc_en: 1'b1, sysclk_internal: 1'b1};
            serial_clk_en <= 1'b0;
            cpu_sleeping <= 1'b0;
            power_mode <= 3'h0;
        end else begin
            clk_ctrl.main_regulator_on <= 1'b1;
            clk_ctrl.core_clk_en <= (next_state != LPMC_STOP0);
            clk_ctrl.pll_en <= (next_state != LPMC_STOP0) && osc[`LPMC_OSC_PLL];
            clk_ctrl.external_highspeed_osc_en <= (next_state != LPMC_STOP0) && osc[`LPMC_OSC_XHS];
            clk_ctrl.internal_16mhz_osc_en <= (next_state != LPMC_STOP0) ||
                (in_stop && serial_clk_req);
            clk_ctrl.io_hold <= (next_state == LPMC_STOP0);
            clk_ctrl.sram_retain <= 1'b1;
            if (stop_exit) begin
                clk_ctrl.sysclk_internal <= 1'b1;
            end
            serial_clk_en <= (next_state == LPMC_STOP0) && serial_clk_req;
            cpu_sleeping <= (next_state != LPMC_RUN) && (next_state != LPMC_LPRUN);
            power_mode <= next_state;
        end
    end

    assign calendar_clk_en = osc[`LPMC_OSC_CAL];
    assign slow_internal_osc_en = osc[`LPMC_OSC_LSI] || wdg_on;
    assign slow_external_osc_en = osc[`LPMC_OSC_LSE];
    assign watchdog_run = wdg_on;

    // interrupt events: stop entered, stop exited, entry cancelled
    wire logic [`LPMC_IRQ_W-1:0] irq_evt = {stop_req && stop_cancel, stop_exit,
                                            (next_state == LPMC_STOP0) && !in_stop};
    assign irq = |(irq_stat & irq_en);

    // axi write path
    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    wire logic wr_go = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
    wire logic [`LPMC_ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire logic [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire logic [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
    wire logic wr_ctrl = wr_go && (wr_addr == `LPMC_OFF_CTRL);
    wire logic wr_osc = wr_go && (wr_addr == `LPMC_OFF_OSC);
    wire logic wr_en = wr_go && (wr_addr == `LPMC_OFF_IRQ_EN);
    wire logic wr_clr = wr_go && (wr_addr == `LPMC_OFF_IRQ_CLR);
    wire logic wr_hit = wr_ctrl || wr_osc || wr_en || wr_clr;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LPMC_RESP_OKAY;
        end else begin
            if (aw_take && !wr_go) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take && !wr_go) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `LPMC_RESP_OKAY : `LPMC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register writes; set beats clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl <= `LPMC_CTRL_RESET;
            osc <= `LPMC_OSC_RESET;
            irq_en <= '0;
            irq_stat <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= lpmc_merge(ctrl, wr_data, wr_strb);
            end
            if (wr_osc) begin
                osc <= lpmc_merge(osc, wr_data, wr_strb);
            end
            if (wr_en) begin
                irq_en <= wr_data[`LPMC_IRQ_W-1:0];
            end
            irq_stat <= (irq_stat & ~(wr_clr ? wr_data[`LPMC_IRQ_W-1:0] : '0)) | irq_evt;
        end
    end

    // axi read path
    wire logic rd_take = s_axi_arvalid && s_axi_arready;
    wire logic rd_ctrl = (s_axi_araddr == `LPMC_OFF_CTRL);
    wire logic rd_osc = (s_axi_araddr == `LPMC_OFF_OSC);
    wire logic rd_stat = (s_axi_araddr == `LPMC_OFF_STAT);
    wire logic rd_istat = (s_axi_araddr == `LPMC_OFF_IRQ_STAT);
    wire logic rd_ien = (s_axi_araddr == `LPMC_OFF_IRQ_EN);
    wire logic rd_clr = (s_axi_araddr == `LPMC_OFF_IRQ_CLR);
    wire logic [31:0] stat_word = {26'h0, wdg_on, cpu_sleeping, 1'b0, power_mode};
    wire logic [31:0] rd_word = rd_ctrl ? ctrl : rd_osc ? osc : rd_stat ? stat_word :
        rd_istat ? {29'h0, irq_stat} : rd_ien ? {29'h0, irq_en} : 32'h0000_0000;
    wire logic rd_hit = rd_ctrl || rd_osc || rd_stat || rd_istat || rd_ien || rd_clr;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `LPMC_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `LPMC_RESP_OKAY : `LPMC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ===== tb/lpmc_ctrl_props.sv
/*
 port checker for the low power mode controller.
 assumes binding to lpmc_ctrl, one clock domain, synchronous nrst.
*/
module lpmc_ctrl_props import lpmc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // watched inputs
    input wire logic flash_prog_busy,
    input wire logic apb_busy,
    input wire logic ext_pending_any,
    input wire logic periph_wakeup_flag,
    input wire logic wdg_key_start,
    input wire logic wdg_hw_option,
    // watched outputs
    input wire lpmc_clk_s clk_ctrl,
    input wire logic serial_clk_en,
    input wire logic watchdog_run,
    input wire logic slow_internal_osc_en,
    input wire logic [2:0] power_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_stop_off;
        power_mode == 3'h5 |-> !clk_ctrl.core_clk_en && !clk_ctrl.pll_en
            && !clk_ctrl.external_highspeed_osc_en && clk_ctrl.main_regulator_on
            && (!clk_ctrl.internal_16mhz_osc_en || serial_clk_en);
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("clocks running in stop");
    property p_serial;
        serial_clk_en |-> power_mode == 3'h5 || $past(power_mode) == 3'h5;
    endproperty
    a_serial: assert property (p_serial) else $error("serial clock outside stop");
    property p_hold;
        power_mode == 3'h5 |-> clk_ctrl.io_hold && clk_ctrl.sram_retain;
    endproperty
    a_hold: assert property (p_hold) else $error("state not held in stop");
    property p_busy;
        power_mode == 3'h5 && $past(power_mode) != 3'h5 |-> !$past(flash_prog_busy) && !$past(apb_busy);
    endproperty
    a_busy: assert property (p_busy) else $error("stop entered while busy");
    property p_wake_clk;
        $fell(power_mode == 3'h5) |-> clk_ctrl.sysclk_internal && clk_ctrl.core_clk_en;
    endproperty
    a_wake_clk: assert property (p_wake_clk) else $error("wrong clock after stop");
    property p_wake_mode;
        $past(power_mode) == 3'h5 && power_mode != 3'h5 |-> power_mode <= 3'h1;
    endproperty
    a_wake_mode: assert property (p_wake_mode) else $error("wrong mode after stop");
    property p_lps_exit;
        $fell(power_mode == 3'h3) |-> power_mode == 3'h1;
    endproperty
    a_lps_exit: assert property (p_lps_exit) else $error("low-power sleep exit not lprun");
    property p_lps_entry;
        $rose(power_mode == 3'h3) |-> $past(power_mode) == 3'h1;
    endproperty
    a_lps_entry: assert property (p_lps_entry) else $error("low-power sleep not from lprun");
    property p_wdg_keep;
        watchdog_run |=> watchdog_run;
    endproperty
    a_wdg_keep: assert property (p_wdg_keep) else $error("watchdog stopped");
    property p_wdg_start;
        wdg_key_start || wdg_hw_option |-> ##[1:2] watchdog_run;
    endproperty
    a_wdg_start: assert property (p_wdg_start) else $error("watchdog not started");
    property p_cancel;
        power_mode <= 3'h1 && (ext_pending_any || periph_wakeup_flag) |=> power_mode < 3'h4;
    endproperty
    a_cancel: assert property (p_cancel) else $error("stop entered with flag pending");
    property p_slow;
        watchdog_run |-> slow_internal_osc_en;
    endproperty
    a_slow: assert property (p_slow) else $error("slow oscillator off under watchdog");
    c_hold: cover property (power_mode == 3'h4 ##1 power_mode == 3'h5);
    c_serial: cover property (serial_clk_en);
    c_lps: cover property ($fell(power_mode == 3'h3));
endmodule
bind lpmc_ctrl lpmc_ctrl_props u_lpmc_ctrl_props (.clk(clk), .nrst(nrst), .flash_prog_busy(flash_prog_busy),
    .apb_busy(apb_busy), .ext_pending_any(ext_pending_any), .periph_wakeup_flag(periph_wakeup_flag),
    .wdg_key_start(wdg_key_start), .wdg_hw_option(wdg_hw_option), .clk_ctrl(clk_ctrl),
    .serial_clk_en(serial_clk_en),
    .watchdog_run(watchdog_run), .slow_internal_osc_en(slow_internal_osc_en), .power_mode(power_mode));

// ===== tb/lpmc_core_model.sv
/*
 core side model: request pulses and wakeup levels.
 assumes calls made right after a rising edge of clk.
*/
module lpmc_core_model import lpmc_pkg::*; (
    // clock
    input wire logic clk,
    // core side
    output lpmc_core_s core
);
    timeunit 1ns;
    timeprecision 1ns;
    initial core = '0;
    task automatic req(input logic [2:0] m);
        @(posedge clk);
        {core.wait_interrupt_instr, core.wait_event_instr, core.isr_return} <= m;
        @(posedge clk);
        {core.wait_interrupt_instr, core.wait_event_instr, core.isr_return} <= 3'h0;
    endtask
    task automatic wake(input logic [3:0] v);
        @(posedge clk);
        {core.irq_pending, core.irq_pending_any, core.event_pending, core.wakeup_event} <= v;
    endtask
endmodule

// ===== tb/tb.sv
/*
 testbench for the low power mode controller.
 assumes lpmc_pkg and lpmc_cfg.svh compiled ahead.
*/
`include "lpmc_cfg.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb import lpmc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    lpmc_core_s core;
    lpmc_clk_s clk_ctrl;
    logic ext, periph, flash, apb, wdg_key, wdg_hw, sreq, serial_clk_en, watchdog_run, cal_en, lsi_en, lse_en;
    logic cpu_sleeping, irq;
    logic [2:0] power_mode;
    logic [31:0] rv [4] = '{32'h10, 32'h0, 32'h0, 32'h0};
    int errors = 0, comparisons = 0, cyc = 0;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    lpmc_core_model u_lpmc_core_model (.clk(clk), .core(core));
    lpmc_ctrl u_lpmc_ctrl (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core(core),
        .ext_pending_any(ext), .periph_wakeup_flag(periph), .flash_prog_busy(flash), .apb_busy(apb),
        .wdg_key_start(wdg_key), .wdg_hw_option(wdg_hw), .serial_clk_req(sreq), .clk_ctrl(clk_ctrl),
        .serial_clk_en(serial_clk_en), .watchdog_run(watchdog_run), .calendar_clk_en(cal_en),
        .slow_internal_osc_en(lsi_en), .slow_external_osc_en(lse_en), .cpu_sleeping(cpu_sleeping),
        .power_mode(power_mode), .irq(irq));
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ta, tw, bk;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bk = 1'b0;
        while (!bk) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            bk = bvalid;
            rs = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, ok;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ok = 1'b0;
        while (!ok) begin
            @(negedge clk);
            ta = arvalid && arready;
            ok = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_pm(input logic [2:0] e);
        for (int i = 0; i < 20 && power_mode !== e; i++) @(negedge clk);
        `CHK("power_mode", e, power_mode)
    endtask
    task automatic req(input logic [2:0] m);
        u_lpmc_core_model.req(m);
    endtask
    task automatic wake(input logic [3:0] v);
        u_lpmc_core_model.wake(v);
    endtask
    task automatic stop_test;
        $display("counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready, ext, periph, flash, apb, wdg_key, wdg_hw, sreq} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4), d, r);
            `CHK("reset reg", {2'h0, rv[i]}, {r, d})
        end
        settle(1);
        `CHK("clk_ctrl", 8'hAB, clk_ctrl)
        rd(8'h18, d, r);
        `CHK("unmapped read", {2'h2, 32'h0}, {r, d})
        wr(`LPMC_OFF_IRQ_STAT, 32'h7, r);
        `CHK("status write", 2'h2, r)
        wr(`LPMC_OFF_IRQ_EN, 32'h7, r);
        $display("test reset done");
        wake(4'h8);
        req(3'h4);
        settle(3);
        `CHK("pending wait", 3'h0, power_mode)
        wake(4'h0);
        req(3'h4);
        wait_pm(3'h2);
        `CHK("cpu_sleeping", 1'b1, cpu_sleeping)
        wake(4'h8);
        wait_pm(3'h0);
        wake(4'h0);
        wr(`LPMC_OFF_CTRL, 32'h18, r);
        wait_pm(3'h1);
        req(3'h2);
        wait_pm(3'h3);
        wake(4'hC);
        settle(5);
        `CHK("event wait idle", 3'h3, power_mode)
        wake(4'h1);
        wait_pm(3'h1);
        wake(4'h0);
        wr(`LPMC_OFF_CTRL, 32'h118, r);
        req(3'h2);
        wait_pm(3'h3);
        wake(4'h4);
        wait_pm(3'h1);
        wake(4'h0);
        wr(`LPMC_OFF_CTRL, 32'h198, r);
        req(3'h1);
        wait_pm(3'h3);
        wake(4'h8);
        wait_pm(3'h1);
        wake(4'h0);
        $display("test sleep done");
        wr(`LPMC_OFF_CTRL, 32'h58, r);
        flash <= 1'b1;
        req(3'h4);
        settle(4);
        `CHK("flash hold", 3'h4, power_mode)
        @(posedge clk);
        flash <= 1'b0;
        wait_pm(3'h5);
        `CHK("stop clocks", 8'h0E, clk_ctrl & 8'hFE)
        `CHK("irq entry", 1'b1, irq)
        @(posedge clk);
        sreq <= 1'b1;
        settle(3);
        `CHK("serial on", 1'b1, serial_clk_en)
        @(posedge clk);
        sreq <= 1'b0;
        settle(3);
        `CHK("serial off", 1'b0, serial_clk_en)
        wake(4'h8);
        wait_pm(3'h1);
        `CHK("sysclk", 1'b1, clk_ctrl.sysclk_internal)
        wake(4'h0);
        rd(`LPMC_OFF_IRQ_STAT, d, r);
        `CHK("irq status", 3'h3, d[2:0])
        wr(`LPMC_OFF_IRQ_CLR, 32'h3, r);
        settle(1);
        `CHK("irq cleared", 1'b0, irq)
        wr(`LPMC_OFF_CTRL, 32'h50, r);
        wait_pm(3'h0);
        apb <= 1'b1;
        req(3'h4);
        settle(4);
        `CHK("apb hold", 3'h4, power_mode)
        @(posedge clk);
        apb <= 1'b0;
        wait_pm(3'h5);
        @(posedge clk);
        ext <= 1'b1;
        wait_pm(3'h0);
        $display("test stop done");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            ext <= (i == 0);
            periph <= (i == 1);
            req(3'h4);
            settle(3);
            `CHK("cancel", 3'h0, power_mode)
        end
        @(posedge clk);
        {ext, periph} <= 2'h0;
        rd(`LPMC_OFF_IRQ_STAT, d, r);
        `CHK("cancel flag", 1'b1, d[2])
        wr(`LPMC_OFF_CTRL, 32'h51, r);
        req(3'h4);
        settle(3);
        `CHK("mode select", 3'h0, power_mode)
        wr(`LPMC_OFF_OSC, 32'h5, r);
        settle(1);
        `CHK("slow clocks", 3'h5, {cal_en, lsi_en, lse_en})
        @(posedge clk);
        wdg_key <= 1'b1;
        @(posedge clk);
        wdg_key <= 1'b0;
        settle(2);
        `CHK("watchdog", 2'h3, {watchdog_run, lsi_en})
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        settle(1);
        `CHK("watchdog reset", 1'b0, watchdog_run)
        `CHK("reset clocks", 8'hA9, clk_ctrl)
        @(posedge clk);
        wdg_hw <= 1'b1;
        @(posedge clk);
        wdg_hw <= 1'b0;
        settle(2);
        `CHK("watchdog option", 1'b1, watchdog_run)
        $display("test misc done");
        stop_test();
    end
endmodule
